// File: include/uartrx_pkg.sv
// Purpose: Constants and types for the serial receiver block
// Assumes: AXI4-Lite register bus, 32-bit data, 25 MHz clock
// Notes:   Entry layout is {overrun, parity err, frame err, data[8:0]}
package uartrx_pkg;
  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [4:0] ADDR_DATA   = 5'h00; // Received data
  localparam logic [4:0] ADDR_STATUS = 5'h04; // Status register
  localparam logic [4:0] ADDR_CTRLB  = 5'h08; // Control register b
  localparam logic [4:0] ADDR_CTRLC  = 5'h0c; // Control register c
  localparam logic [4:0] ADDR_BAUD   = 5'h10; // Sample divisor
  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int ST_RXC  = 7; // Receive complete flag
  localparam int ST_FE   = 4; // Frame error flag
  localparam int ST_DOR  = 3; // Overrun flag
  localparam int ST_UPE  = 2; // Parity error flag
  localparam int ST_DBL  = 1; // Double speed select
  localparam int CB_IE   = 7; // Receive complete irq enable
  localparam int CB_EN   = 4; // Receiver enable
  localparam int CB_RB8  = 1; // Received ninth bit
  localparam int CC_PEN  = 5; // Parity enable
  localparam int CC_PODD = 4; // Parity odd select
  localparam int CC_STP2 = 3; // Two stop bits select
  localparam int E_FE    = 9;  // Entry frame error
  localparam int E_UPE   = 10; // Entry parity error
  localparam int E_DOR   = 11; // Entry overrun
  // ==========================================================
  // Reset values and timing counts
  // ==========================================================
  localparam logic [2:0] CSZ_RST  = 3'h3; // Eight data bits
  localparam logic [2:0] CSZ_NINE = 3'h7; // Nine data bits code
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [4:0] SPB_NORM = 5'h10; // 16 samples per bit
  localparam logic [4:0] SPB_DBL  = 5'h08; // 8 samples per bit
  localparam logic [4:0] VOTE_NRM = 5'h08; // First vote sample
  localparam logic [4:0] VOTE_DBL = 5'h04;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Receiver states, one-hot
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } uartrx_st_e;
endpackage : uartrx_pkg

// File: rtl/uartrx_receiver.sv
// Purpose: Asynchronous serial receiver with two-entry buffer
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes:   Sample tick every div+1 clocks
// Notes on behaviour
// - Complete flag high while buffer nonempty
// - Clearing enable flushes buffer
// - Irq level equals flag and enable
// - Errors stored per entry; data read pops
// - Error flag writes ignored
// - Error flags raise no interrupt
// - Frame error equals inverted stop vote
// - Only first stop bit examined
// - Overrun when full, pending, new start
// - Overrun clears on move into buffer
// - Parity error only with checking enabled
// - Parity odd or even checked
// - Disable abandons frame, releases pin
// - Sample at 16x or 8x baud
// - Vote start on samples 8-10 or 4-6
// - Resynchronise on every start bit
// - Sixteen or eight states per bit
// - Majority of three centre samples
// - Idle right after stop vote
// - Move into buffer after first stop
// - Unused upper data bits read zero
// - Votes start at sample 8 or 4
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
module uartrx_receiver #(
  parameter int DIV_W = 8 // Sample divisor width
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Serial line
  input  wire logic        rxd_i,
  output logic             rx_pin_override_o,
  output logic             rx_irq_o,
  // AXI4-Lite write
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] awaddr_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  // AXI4-Lite read
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [31:0] araddr_i,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o
);
  // ==========================================================
  // Parameter check
  // ==========================================================
  if (DIV_W != 8) begin : g_chk
    $error("DIV_W must be 8");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic                   s1;    // Sync stage one
    logic                   s2;    // Sync stage two
    logic [7:0]             dcnt;  // Divider count
    logic                   tick;  // Sample strobe
    logic [7:0]             div;   // Divisor
    logic                   en;    // Receiver enable
    logic                   ie;    // Irq enable
    logic                   dbl;   // Double speed
    logic                   pen;   // Parity enable
    logic                   podd;  // Odd parity
    logic                   stp2;  // Two stop bits (tx only)
    logic [2:0]             csz;   // Character size code
    uartrx_pkg::uartrx_st_e st;    // Receiver state
    logic [4:0]             samp;  // Current sample number
    logic [1:0]             vot;   // First two votes
    logic [3:0]             bitn;  // Data bit index
    logic [8:0]             sh;    // Shift register
    logic                   rpar;  // Received parity
    logic [11:0]            pend;  // Waiting character
    logic                   pv;    // Waiting valid
    logic                   ovr;   // Overrun pending
    logic [1:0][11:0]       fifo;  // Receive buffer
    logic                   rp;    // Read pointer
    logic [1:0]             cnt;   // Entries held
    logic                   bv;    // Write response valid
    logic [1:0]             br;    // Write response code
    logic                   rv;    // Read response valid
    logic [31:0]            rd;    // Read data
    logic [1:0]             rr;    // Read response code
  } uartrx_state_s;

  uartrx_state_s q_r;   // Registered state
  uartrx_state_s q_nxt; // Next state

  // Per-cycle helpers
  logic [4:0]  spb;    // Samples per bit
  logic [4:0]  vs;     // First vote sample
  logic [4:0]  sn;     // Sample number being taken
  logic [3:0]  nb;     // Data bits per frame
  logic        maj;    // Majority result
  logic        wr;     // Write accepted
  logic        rd;     // Read accepted
  logic        pushed; // Waiting character moved into buffer this cycle
  logic [11:0] ent;    // Completed entry
  logic [11:0] head;   // Next readable entry

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    q_nxt  = q_r;
    spb    = q_r.dbl ? uartrx_pkg::SPB_DBL : uartrx_pkg::SPB_NORM;
    vs     = q_r.dbl ? uartrx_pkg::VOTE_DBL : uartrx_pkg::VOTE_NRM;
    sn     = (q_r.samp == spb) ? 5'h01 : q_r.samp + 5'h01;
    // Size codes 0..3 give five to eight data bits, code 7 gives nine
    nb     = (q_r.csz == uartrx_pkg::CSZ_NINE) ? 4'h9 : {2'b00, q_r.csz[1:0]} + 4'h5;
    maj    = (q_r.vot[1] & q_r.vot[0]) | (q_r.vot[1] & q_r.s2)
           | (q_r.vot[0] & q_r.s2);
    wr     = awvalid_i & wvalid_i & ~q_r.bv;
    rd     = arvalid_i & ~q_r.rv;
    pushed = 1'b0;
    head   = (q_r.cnt != 2'h0) ? q_r.fifo[q_r.rp] : 12'h000;
    ent    = {q_r.ovr,
              q_r.pen & (q_r.rpar != (^q_r.sh ^ q_r.podd)),
              ~maj, q_r.sh};

    // Input synchroniser
    q_nxt.s1 = rxd_i;
    q_nxt.s2 = q_r.s1;

    // Sample rate divider
    q_nxt.tick = 1'b0;
    if (q_r.dcnt >= q_r.div) begin
      q_nxt.dcnt = 8'h00;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.dcnt = q_r.dcnt + 8'h01;
    end

    // Write channel
    if (q_r.bv && bready_i) begin
      q_nxt.bv = 1'b0;
    end
    if (wr) begin
      q_nxt.bv = 1'b1;
      q_nxt.br = uartrx_pkg::RESP_OK;
      case (awaddr_i[4:0])
        uartrx_pkg::ADDR_DATA: begin
          // No transmitter behind this location
        end
        uartrx_pkg::ADDR_STATUS: begin
          // Error flag positions are read-only
          if (wstrb_i[0]) q_nxt.dbl = wdata_i[uartrx_pkg::ST_DBL];
        end
        uartrx_pkg::ADDR_CTRLB: begin
          if (wstrb_i[0]) begin
            q_nxt.ie = wdata_i[uartrx_pkg::CB_IE];
            q_nxt.en = wdata_i[uartrx_pkg::CB_EN];
          end
        end
        uartrx_pkg::ADDR_CTRLC: begin
          if (wstrb_i[0]) begin
            q_nxt.pen  = wdata_i[uartrx_pkg::CC_PEN];
            q_nxt.podd = wdata_i[uartrx_pkg::CC_PODD];
            q_nxt.stp2 = wdata_i[uartrx_pkg::CC_STP2];
            q_nxt.csz  = wdata_i[2:0];
          end
        end
        uartrx_pkg::ADDR_BAUD: begin
          if (wstrb_i[0]) q_nxt.div = wdata_i[7:0];
        end
        default: begin
          q_nxt.br = uartrx_pkg::RESP_ERR; // Unmapped
        end
      endcase
    end

    // Read channel
    if (q_r.rv && rready_i) begin
      q_nxt.rv = 1'b0;
    end
    if (rd) begin
      q_nxt.rv = 1'b1;
      q_nxt.rr = uartrx_pkg::RESP_OK;
      q_nxt.rd = 32'h0000_0000;
      case (araddr_i[4:0])
        uartrx_pkg::ADDR_DATA: begin
          q_nxt.rd[7:0] = head[7:0];
          // Data read advances the buffer
          if (q_r.cnt != 2'h0) begin
            q_nxt.rp  = ~q_r.rp;
            q_nxt.cnt = q_r.cnt - 2'h1;
          end
        end
        uartrx_pkg::ADDR_STATUS: begin
          q_nxt.rd[uartrx_pkg::ST_RXC] = (q_r.cnt != 2'h0);
          q_nxt.rd[uartrx_pkg::ST_FE]  = head[uartrx_pkg::E_FE];
          q_nxt.rd[uartrx_pkg::ST_DOR] = head[uartrx_pkg::E_DOR];
          q_nxt.rd[uartrx_pkg::ST_UPE] = head[uartrx_pkg::E_UPE];
          q_nxt.rd[uartrx_pkg::ST_DBL] = q_r.dbl;
        end
        uartrx_pkg::ADDR_CTRLB: begin
          q_nxt.rd[uartrx_pkg::CB_IE]  = q_r.ie;
          q_nxt.rd[uartrx_pkg::CB_EN]  = q_r.en;
          q_nxt.rd[uartrx_pkg::CB_RB8] = head[8];
        end
        uartrx_pkg::ADDR_CTRLC: begin
          q_nxt.rd[uartrx_pkg::CC_PEN]  = q_r.pen;
          q_nxt.rd[uartrx_pkg::CC_PODD] = q_r.podd;
          q_nxt.rd[uartrx_pkg::CC_STP2] = q_r.stp2;
          q_nxt.rd[2:0]                 = q_r.csz;
        end
        uartrx_pkg::ADDR_BAUD: begin
          q_nxt.rd[7:0] = q_r.div;
        end
        default: begin
          q_nxt.rr = uartrx_pkg::RESP_ERR; // Unmapped
        end
      endcase
    end

    // Waiting character moves in once there is room
    if (q_r.pv && q_nxt.cnt != 2'h2) begin
      q_nxt.fifo[q_nxt.rp ^ q_nxt.cnt[0]] = {q_r.ovr, q_r.pend[10:0]};
      q_nxt.cnt = q_nxt.cnt + 2'h1;
      q_nxt.pv  = 1'b0;
      q_nxt.ovr = 1'b0;
      pushed    = 1'b1;
    end

    // Frame recovery, one step per sample
    if (q_r.tick) begin
      q_nxt.samp = sn;
      if (sn == vs || sn == vs + 5'h01) begin
        q_nxt.vot = {q_r.vot[0], q_r.s2};
      end
      case (q_r.st)
        uartrx_pkg::RX_IDLE: begin
          // First low sample is number one
          if (!q_r.s2) begin
            q_nxt.st   = uartrx_pkg::RX_START;
            q_nxt.samp = 5'h01;
            q_nxt.sh   = 9'h000;
            q_nxt.bitn = 4'h0;
          end
        end
        uartrx_pkg::RX_START: begin
          if (sn == vs + 5'h02) begin
            if (maj) begin
              q_nxt.st = uartrx_pkg::RX_IDLE;
            end else if (q_nxt.cnt == 2'h2 && q_nxt.pv) begin
              q_nxt.ovr = 1'b1;
            end
          end else if (q_r.samp == spb) begin
            q_nxt.st = uartrx_pkg::RX_DATA;
          end
        end
        uartrx_pkg::RX_DATA: begin
          if (sn == vs + 5'h02) begin
            q_nxt.sh[q_r.bitn] = maj;
          end else if (q_r.samp == spb) begin
            if (q_r.bitn == nb - 4'h1) begin
              q_nxt.st = q_r.pen ? uartrx_pkg::RX_PAR : uartrx_pkg::RX_STOP;
            end else begin
              q_nxt.bitn = q_r.bitn + 4'h1;
            end
          end
        end
        uartrx_pkg::RX_PAR: begin
          if (sn == vs + 5'h02) begin
            q_nxt.rpar = maj;
          end else if (q_r.samp == spb) begin
            q_nxt.st = uartrx_pkg::RX_STOP;
          end
        end
        uartrx_pkg::RX_STOP: begin
          // Finish on first stop vote; later stop bits ignored
          if (sn == vs + 5'h02) begin
            q_nxt.st = uartrx_pkg::RX_IDLE;
            if (!pushed && !q_nxt.pv && q_nxt.cnt != 2'h2) begin
              q_nxt.fifo[q_nxt.rp ^ q_nxt.cnt[0]] = ent;
              q_nxt.fifo[q_nxt.rp ^ q_nxt.cnt[0]][uartrx_pkg::E_DOR] = q_r.ovr;
              q_nxt.cnt = q_nxt.cnt + 2'h1;
              q_nxt.ovr = 1'b0;
            end else begin
              q_nxt.pend = ent;
              q_nxt.pv   = 1'b1;
            end
          end
        end
        default: begin
          q_nxt.st = uartrx_pkg::RX_IDLE;
        end
      endcase
    end

    // Disable is immediate: abandon frame, flush buffer
    if (!q_nxt.en) begin
      q_nxt.st  = uartrx_pkg::RX_IDLE;
      q_nxt.cnt = 2'h0;
      q_nxt.pv  = 1'b0;
      q_nxt.ovr = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q_r      <= '0;
      q_r.s1   <= 1'b1;
      q_r.s2   <= 1'b1;
      q_r.st   <= uartrx_pkg::RX_IDLE;
      q_r.csz  <= uartrx_pkg::CSZ_RST;
      q_r.div  <= uartrx_pkg::DIV_RST;
      q_r.samp <= 5'h01;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign rx_irq_o          = (q_r.cnt != 2'h0) & q_r.ie;
  assign rx_pin_override_o = q_r.en;
  assign awready_o         = wr;
  assign wready_o          = wr;
  assign bvalid_o          = q_r.bv;
  assign bresp_o           = q_r.br;
  assign arready_o         = ~q_r.rv;
  assign rvalid_o          = q_r.rv;
  assign rdata_o           = q_r.rd;
  assign rresp_o           = q_r.rr;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  flush_on_dis_a: assert property (!q_r.en |=> q_r.cnt == 2'h0)
    else $error("buffer not flushed while disabled");
  irq_level_a: assert property (rx_irq_o == (q_r.ie && q_r.cnt != 2'h0))
    else $error("irq does not follow flag and enable");
  start_reject_a: assert property (q_r.tick && q_r.st == uartrx_pkg::RX_START
    && sn == vs + 5'h02 && maj && q_r.en |=> q_r.st == uartrx_pkg::RX_IDLE)
    else $error("noisy start bit not rejected");
  stop_idle_a: assert property (q_r.tick && q_r.st == uartrx_pkg::RX_STOP
    && sn == vs + 5'h02 |=> q_r.st == uartrx_pkg::RX_IDLE)
    else $error("not idle after stop vote");
  ovr_full_a: assert property ($rose(q_r.ovr) |-> $past(q_r.cnt) == 2'h2
    && $past(q_r.pv))
    else $error("overrun without full buffer");
  // A frame landing or a disable in the same cycle would refill or empty it
  pop_read_a: assert property (rd && araddr_i[4:0] == uartrx_pkg::ADDR_DATA
    && q_r.cnt == 2'h2 && q_r.en && !q_r.pv && !wr
    && q_r.st != uartrx_pkg::RX_STOP |=> q_r.cnt == 2'h1)
    else $error("data read did not advance buffer");
  // Entry stored into an empty buffer while checking is off carries no parity error
  par_off_a: assert property (q_r.tick && q_r.st == uartrx_pkg::RX_STOP
    && sn == vs + 5'h02 && !q_r.pen && q_r.cnt == 2'h0 && !q_r.pv
    |=> !q_r.fifo[q_r.rp][uartrx_pkg::E_UPE])
    else $error("parity error stored while checking off");
  tick_gap_a: assert property (q_r.tick && q_r.div == 8'h01
    && $stable(q_r.div) |=> !q_r.tick ##1 q_r.tick)
    else $error("sample spacing wrong");
  samp_rng_a: assert property (q_r.samp >= 5'h01 && q_r.samp <= spb
    || q_r.st == uartrx_pkg::RX_IDLE)
    else $error("sample number out of range");

  frame_c: cover property (q_r.st == uartrx_pkg::RX_STOP ##1
    q_r.st == uartrx_pkg::RX_IDLE);
  ovr_c:   cover property ($rose(q_r.ovr));
  rej_c:   cover property (q_r.st == uartrx_pkg::RX_START ##1
    q_r.st == uartrx_pkg::RX_IDLE);
  par_c:   cover property (q_r.cnt != 2'h0 && head[uartrx_pkg::E_UPE]);
endmodule : uartrx_receiver

// File: dv/uartrx_tx_model.sv
// Purpose: Remote serial transmitter that drives the receive line
// Assumes: Bit and stop lengths are given in clocks by the caller
// Notes:   Line idles high between frames; parity can be sent wrong
module uartrx_tx_model (
  // Clock
  input  wire logic clk_i,
  // Serial line
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle level before the first frame
  initial rxd_o = 1'b1;
  // ==========================================================
  // Line drivers
  // ==========================================================
  // Hold one level for n clocks, changed just after an edge
  task automatic hold(input logic v, input int n);
    rxd_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : hold
  // Start bit, data LSB first, optional parity, first stop bit
  task automatic send(input logic [8:0] d, input int nb, input logic pen,
                      input logic podd, input logic pbad, input logic stp,
                      input int bc, input int sc);
    logic p;
    p = podd ^ pbad;
    @(posedge clk_i);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++) begin
      p = p ^ d[i];
      hold(d[i], bc);
    end
    // Even or odd parity over the sent data bits
    if (pen) begin
      hold(p, bc);
    end
    hold(stp, sc);
    rxd_o <= 1'b1;
  endtask : send
endmodule : uartrx_tx_model

// File: dv/tb_top.sv
// Purpose: Register level test of the serial receiver
// Assumes: Divisor mostly 0, so one sample per clock
// Notes:   Bus checked at falling edge, driven after rising edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam logic [4:0] A_D = uartrx_pkg::ADDR_DATA;
  localparam logic [4:0] A_S = uartrx_pkg::ADDR_STATUS;
  localparam logic [4:0] A_B = uartrx_pkg::ADDR_CTRLB;
  localparam logic [4:0] A_C = uartrx_pkg::ADDR_CTRLC;
  localparam logic [4:0] A_V = uartrx_pkg::ADDR_BAUD;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        rxd;
  logic        awvalid  = 1'b0;
  logic [31:0] awaddr   = 32'h0;
  logic        wvalid   = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic [31:0] araddr   = 32'h0;
  logic        rready   = 1'b0;
  logic        ovr, irq, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rdv;
  int          n_errors    = 0;
  int          check_count = 0;
  int          cycles      = 0;
  // ==========================================================
  // Design, line partner and clock
  // ==========================================================
  uartrx_receiver #(.DIV_W(8)) u_uartrx_receiver (
    .core_clk_i(core_clk), .nrst_i(nrst), .rxd_i(rxd),
    .rx_pin_override_o(ovr), .rx_irq_o(irq),
    .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'hf),
    .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
    .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp)
  );
  uartrx_tx_model u_uartrx_tx_model (.clk_i(core_clk), .rxd_o(rxd));
  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      n_errors = n_errors + 1;
    end
  endtask : chk
  // Bus write; address and data each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p, w_p, ta, tw;
    aw_p = 1'b1;
    w_p = 1'b1;
    awvalid <= 1'b1;
    awaddr <= {27'h0, a};
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge core_clk);
      ta = aw_p && (awready === 1'b1);
      tw = w_p && (wready === 1'b1);
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      aw_p = aw_p && !ta;
      w_p = w_p && !tw;
    end
    do @(negedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge core_clk);
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Bus read
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    arvalid <= 1'b1;
    araddr <= {27'h0, a};
    rready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge core_clk);
      t = (arready === 1'b1);
      @(posedge core_clk);
    end
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  // Write expecting an OKAY answer
  task automatic wrc(input logic [4:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk({30'h0, rsp}, {30'h0, uartrx_pkg::RESP_OK});
  endtask : wrc
  // Read expecting OKAY and a value
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    rd(a, rdv, rsp);
    chk({30'h0, rsp}, {30'h0, uartrx_pkg::RESP_OK});
    chk(rdv, e);
  endtask : rdc
  // One frame with full stop bit, then let it land
  task automatic snd(input logic [8:0] d, input int nb, input logic [2:0] pf,
                     input logic stp, input int bc);
    u_uartrx_tx_model.send(d, nb, pf[2], pf[1], pf[0], stp, bc, bc);
    repeat (8) @(posedge core_clk);
  endtask : snd
  // Verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // Reset values and an unmapped place
    rdc(A_S, 32'h0);
    rdc(A_C, 32'h3);
    rdc(A_V, 32'h0);
    rd(5'h14, rdv, rsp);
    chk({30'h0, rsp}, {30'h0, uartrx_pkg::RESP_ERR});
    chk({31'h0, ovr}, 32'h0);
    // Plain frame with interrupt enabled
    wrc(A_B, 32'h90);
    chk({31'h0, ovr}, 32'h1);
    snd(9'h0a5, 8, 3'b000, 1'b1, 16);
    chk({31'h0, irq}, 32'h1);
    rdc(A_S, 32'h80);
    rdc(A_D, 32'ha5);
    rdc(A_S, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Frame error, interrupt masked, flag writes ignored
    wrc(A_B, 32'h10);
    snd(9'h03c, 8, 3'b000, 1'b0, 16);
    chk({31'h0, irq}, 32'h0);
    wrc(A_S, 32'h1c);
    rdc(A_S, 32'h90);
    rdc(A_D, 32'h3c);
    // Two stop bits selected, one sent
    wrc(A_C, 32'h0b);
    rdc(A_C, 32'h0b);
    snd(9'h0c3, 8, 3'b000, 1'b1, 16);
    rdc(A_S, 32'h80);
    rdc(A_D, 32'hc3);
    // Even and odd parity, good and bad
    for (int k = 0; k < 4; k++) begin
      wrc(A_C, 32'h23 | {27'h0, k[1], 4'h0});
      snd(9'h0b7, 8, {1'b1, k[1], k[0]}, 1'b1, 16);
      rdc(A_S, k[0] ? 32'h84 : 32'h80);
      rdc(A_D, 32'hb7);
    end
    // Four frames into a two-entry buffer
    wrc(A_C, 32'h03);
    for (int k = 1; k < 5; k++) begin
      snd(9'(k * 17), 8, 3'b000, 1'b1, 16);
    end
    rdc(A_S, 32'h80);
    rdc(A_D, 32'h11);
    rdc(A_S, 32'h80);
    rdc(A_D, 32'h22);
    rdc(A_S, 32'h88);
    rdc(A_D, 32'h44);
    rdc(A_S, 32'h0);
    snd(9'h055, 8, 3'b000, 1'b1, 16);
    rdc(A_S, 32'h80);
    rdc(A_D, 32'h55);
    // Disable flushes and abandons a frame in flight
    snd(9'h066, 8, 3'b000, 1'b1, 16);
    wrc(A_B, 32'h00);
    chk({31'h0, ovr}, 32'h0);
    wrc(A_B, 32'h10);
    rdc(A_S, 32'h0);
    fork
      snd(9'h099, 8, 3'b000, 1'b1, 16);
      begin
        repeat (64) @(posedge core_clk);
        wrc(A_B, 32'h00);
      end
    join
    wrc(A_B, 32'h10);
    rdc(A_S, 32'h0);
    // Start pulses at the voting boundary
    u_uartrx_tx_model.hold(1'b0, 8);
    u_uartrx_tx_model.hold(1'b1, 200);
    rdc(A_S, 32'h0);
    u_uartrx_tx_model.hold(1'b0, 9);
    u_uartrx_tx_model.hold(1'b1, 200);
    rdc(A_D, 32'hff);
    // Next start right after the stop votes
    u_uartrx_tx_model.send(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 9);
    snd(9'h0c3, 8, 3'b000, 1'b1, 16);
    rdc(A_D, 32'h5a);
    rdc(A_D, 32'hc3);
    // Double speed, then a slower divisor
    wrc(A_S, 32'h02);
    snd(9'h069, 8, 3'b000, 1'b1, 8);
    rdc(A_S, 32'h82);
    rdc(A_D, 32'h69);
    wrc(A_S, 32'h00);
    wrc(A_V, 32'h01);
    rdc(A_V, 32'h01);
    snd(9'h0e1, 8, 3'b000, 1'b1, 32);
    rdc(A_D, 32'he1);
    wrc(A_V, 32'h00);
    // Five-bit and nine-bit characters
    wrc(A_C, 32'h00);
    snd(9'h0ff, 5, 3'b000, 1'b1, 16);
    rdc(A_D, 32'h1f);
    wrc(A_C, 32'h07);
    snd(9'h1a5, 9, 3'b000, 1'b1, 16);
    rdc(A_B, 32'h12);
    rdc(A_D, 32'ha5);
    summarize();
  end
endmodule : tb_top
